// ===== bench/dsu_term.sv
// Remote terminal model on the serial line
`timescale 1ns/10ps
`default_nettype none
module dsu_term (
  // Clock
  input wire logic clk_sys_i,
  // Serial line
  input wire logic txd_i,
  output logic rxd_o
);
  int bit_len = 6;
  logic [8:0] got[$];
  logic [8:0] sh;
  initial rxd_o = 1'b1;
  task automatic send(input logic [7:0] b, input logic stp);
    logic [9:0] f;
    f = {stp, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd_o <= f[i];
      repeat (bit_len) @(posedge clk_sys_i);
    end
    rxd_o <= 1'b1;
    repeat (bit_len) @(posedge clk_sys_i);
  endtask
  always begin
    @(negedge txd_i);
    repeat (bit_len / 2) @(posedge clk_sys_i);
    for (int i = 0; i < 9; i++) begin
      repeat (bit_len) @(posedge clk_sys_i);
      sh = {txd_i, sh[8:1]};
    end
    got.push_back(sh);
  end
endmodule // dsu_term
`default_nettype wire

// ===== bench/dsu_uart_monitor.sv
// Port checker for the debug serial port
`timescale 1ns/10ps
`default_nettype none
module dsu_uart_monitor (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  // Register port
  input wire dsu_pkg::dsu_bus_req_type bus_i,
  input wire logic [15:0] rdata_o,
  // Serial line and requests
  input wire logic rxd_i,
  input wire logic txd_o,
  input wire logic tx_irq_o,
  input wire logic rx_irq_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  sequence s_rd(a);
    bus_i.rd && bus_i.addr == a;
  endsequence
  a_rdata_quiet: assert property (!bus_i.rd |=> rdata_o == 16'h0000)
    else $error("read data not zero");
  a_low_upper_zero: assert property (s_rd(16'hc029) |=> rdata_o[15:8] == 8'h00)
    else $error("low data upper byte set");
  a_high_lower_zero: assert property (s_rd(16'hc02a) |=> rdata_o[7:0] == 8'h00)
    else $error("high data lower byte set");
  a_status_width: assert property (s_rd(16'hc028) |=> rdata_o[15:4] == 12'h000)
    else $error("status upper bits set");
  a_tx_irq_start: assert property (tx_irq_o |-> !txd_o && $past(txd_o))
    else $error("transmit request without start bit");
  a_tx_irq_pulse: assert property (tx_irq_o |=> !tx_irq_o)
    else $error("transmit request too long");
  a_rx_irq_pulse: assert property (rx_irq_o |=> !rx_irq_o)
    else $error("receive request too long");
  a_rx_stop_high: assert property (rx_irq_o |-> $past(rxd_i) && $past(rxd_i, 2))
    else $error("receive request without stop bit");
endmodule // dsu_uart_monitor
bind dsu_uart dsu_uart_monitor i_mon (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .bus_i(bus_i),
  .rdata_o(rdata_o), .rxd_i(rxd_i), .txd_o(txd_o), .tx_irq_o(tx_irq_o), .rx_irq_o(rx_irq_o));
`default_nettype wire

// ===== bench/dsu_uart_test.sv
// Self-checking bench for the debug serial port
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin err_count++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
module dsu_uart_test;
  logic clk_sys_i = 1'b0;
  logic rstn_i = 1'b0;
  dsu_pkg::dsu_bus_req_type req = '0;
  logic rxd, txd, tx_irq, rx_irq;
  logic [15:0] rdata;
  int err_count = 0;
  int checks = 0;
  int ntx = 0;
  int nrx = 0;
  always #25 clk_sys_i = ~clk_sys_i;
  dsu_uart i_dut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .bus_i(req), .rdata_o(rdata),
    .rxd_i(rxd), .txd_o(txd), .tx_irq_o(tx_irq), .rx_irq_o(rx_irq));
  dsu_term i_term (.clk_sys_i(clk_sys_i), .txd_i(txd), .rxd_o(rxd));
  always @(posedge clk_sys_i) begin
    if (tx_irq === 1'b1) ntx++;
    if (rx_irq === 1'b1) nrx++;
  end
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys_i);
    req <= '0;
    @(posedge clk_sys_i);
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] e);
    req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys_i);
    req <= '0;
    #1 `CHK("rdata", e, rdata)
    @(posedge clk_sys_i);
  endtask
  task automatic getb(input logic [8:0] e);
    logic [8:0] v;
    v = 9'bx;
    for (int i = 0; i < 3000 && i_term.got.size() == 0; i++) @(posedge clk_sys_i);
    if (i_term.got.size() > 0) v = i_term.got.pop_front();
    `CHK("frame", e, v)
  endtask
  task close_out;
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    err_count++;
    close_out;
  end
  initial begin
    repeat (3) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    @(posedge clk_sys_i);
    rd(16'hc02b, 16'h0000);
    rd(16'hc028, 16'h0000);
    wr(16'hc02b, 16'h0006);
    rd(16'hc02b, 16'h0006);
    wr(16'hc029, 16'ha355);
    wr(16'hc02a, 16'h3c00);
    rd(16'hc028, 16'h0003);
    getb(9'h155);
    getb(9'h13c);
    repeat (6) @(posedge clk_sys_i);
    rd(16'hc028, 16'h0000);
    `CHK("tx_irq", 2, ntx)
    i_term.send(8'hc3, 1'b1);
    rd(16'hc028, 16'h0004);
    i_term.send(8'h5a, 1'b1);
    rd(16'hc028, 16'h000c);
    rd(16'hc029, 16'h005a);
    rd(16'hc028, 16'h0008);
    i_term.send(8'h81, 1'b1);
    rd(16'hc028, 16'h0004);
    rd(16'hc02a, 16'h8100);
    i_term.send(8'hff, 1'b0);
    rd(16'hc028, 16'h0000);
    rd(16'hc029, 16'h0081);
    `CHK("rx_irq", 3, nrx)
    wr(16'hc02b, 16'h0106);
    i_term.bit_len = 12;
    wr(16'hc029, 16'h00a5);
    getb(9'h1a5);
    i_term.send(8'h3c, 1'b1);
    rd(16'hc029, 16'h003c);
    close_out;
  end
endmodule // dsu_uart_test
`default_nettype wire

// ===== hw/dsu_pkg.sv
// Shared constants and types of the debug serial port
package dsu_pkg;
  // Register addresses
  localparam logic [15:0] DSU_ADDR_LINE_STATUS = 16'hc028;
  localparam logic [15:0] DSU_ADDR_BYTE_LOW = 16'hc029;
  localparam logic [15:0] DSU_ADDR_BYTE_HIGH = 16'hc02a;
  localparam logic [15:0] DSU_ADDR_BIT_RATE_DIVIDER = 16'hc02b;
  // Status field positions
  localparam int DSU_ST_RECEIVE_OVERRUN = 3;
  localparam int DSU_ST_RECEIVE_FULL = 2;
  localparam int DSU_ST_TRANSMIT_FULL = 1;
  localparam int DSU_ST_TRANSMITTER_RUNNING = 0;
  // Divider field positions
  localparam int DSU_FIRST_DIVIDER_LSB = 8;
  localparam int DSU_SECOND_DIVIDER_LSB = 0;
  // Reset values
  localparam logic [15:0] DSU_DIVIDER_RESET = 16'h0000;
  localparam logic [7:0] DSU_BYTE_RESET = 8'h00;
  // Frame layout
  localparam logic [3:0] DSU_FRAME_LAST_BIT = 4'h9;
  localparam logic [2:0] DSU_DATA_LAST_BIT = 3'h7;
  // Register port request
  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } dsu_bus_req_type;
  typedef enum logic [1:0] {DSU_RX_IDLE, DSU_RX_START, DSU_RX_DATA, DSU_RX_STOP} dsu_rx_state_type;
  typedef enum logic {DSU_TX_IDLE, DSU_TX_SHIFT} dsu_tx_state_type;
endpackage

// ===== hw/dsu_uart.sv
// Debug serial port: registers, divider, transmitter and receiver
// What this block does
// RL1 - Frames are 8 data, no parity, 1 stop
// RL2 - Idle high, start, LSB first, stop
// RL3 - Overrun set when new byte replaces unread
// RL4 - Receive full while unread byte held
// RL5 - Transmit full while holding register occupied
// RL6 - Running flag while shift register sends
// RL7 - Low data read: byte low, zeros high
// RL8 - Data read clears receive full
// RL9 - Receive interrupt on each byte transfer
// RL10 - Low data write takes bits 7:0
// RL11 - Idle write starts frame, transmit interrupt
// RL12 - Busy write held until frame ends
// RL13 - High data uses bits 15:8
// RL14 - Divider resets to zero
// RL15 - Upper byte first, lower byte second
// RL16 - Software keeps second divider 6..255
// RL17 - Bit rate clock over (D1+1)*D2
// RL18 - Idle receiver starts on falling edge
// RL19 - Sample data bits mid-bit, LSB first
// RL20 - Good stop bit transfers and flags
// RL21 - Receiver samples on first stage clock
// RL22 - Software never writes while transmit full
// RL23 - Bad stop bit drops the byte
`timescale 1ns/10ps
`default_nettype none
module dsu_uart (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  // Register port
  input wire dsu_pkg::dsu_bus_req_type bus_i,
  output logic [15:0] rdata_o,
  // Serial line
  input wire logic rxd_i,
  output logic txd_o,
  // Interrupt requests
  output logic tx_irq_o,
  output logic rx_irq_o
);

  function automatic logic period_end(input logic [7:0] cnt, input logic [7:0] lim);
    period_end = (lim == 8'h00) ? 1'b1 : (cnt == lim - 8'h01);
  endfunction

  logic [15:0] div_r;
  logic [7:0] first_div;
  logic [7:0] second_div;
  logic [7:0] cnt1_r;
  logic tick1;
  logic [15:0] rdata_r;
  logic wr_low;
  logic wr_high;
  logic wr_byte;
  logic rd_data;
  logic [7:0] wbyte;
  dsu_pkg::dsu_tx_state_type tx_state_r;
  logic [9:0] tx_shift_r;
  logic [3:0] tx_bit_r;
  logic [7:0] tx_cnt_r;
  logic [7:0] tx_hold_r;
  logic txfull_r;
  logic tx_irq_r;
  logic tx_bit_end;
  logic frame_done;
  logic start_direct;
  logic start_hold;
  logic [7:0] tx_byte;
  dsu_pkg::dsu_rx_state_type rx_state_r;
  logic rx_prev_r;
  logic [7:0] rx_cnt_r;
  logic [2:0] rx_bits_r;
  logic [7:0] rx_shift_r;
  logic [7:0] rx_hold_r;
  logic rxfull_r;
  logic overrun_r;
  logic rx_irq_r;
  logic rx_take;
  logic [3:0] status;

  // RL15 - Divider fields
  assign first_div = div_r[dsu_pkg::DSU_FIRST_DIVIDER_LSB +: 8];
  assign second_div = div_r[dsu_pkg::DSU_SECOND_DIVIDER_LSB +: 8];

  // Register decode
  assign wr_low = bus_i.wr && (bus_i.addr == dsu_pkg::DSU_ADDR_BYTE_LOW);
  assign wr_high = bus_i.wr && (bus_i.addr == dsu_pkg::DSU_ADDR_BYTE_HIGH);
  assign wr_byte = wr_low || wr_high;
  assign rd_data = bus_i.rd && ((bus_i.addr == dsu_pkg::DSU_ADDR_BYTE_LOW) ||
                                (bus_i.addr == dsu_pkg::DSU_ADDR_BYTE_HIGH));
  // RL10 RL13 - Byte lane select
  assign wbyte = wr_high ? bus_i.wdata[15:8] : bus_i.wdata[7:0];

  // RL14 - Divider register reset
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      div_r <= dsu_pkg::DSU_DIVIDER_RESET;
    end else if (bus_i.wr && (bus_i.addr == dsu_pkg::DSU_ADDR_BIT_RATE_DIVIDER)) begin
      div_r <= bus_i.wdata;
    end
  end

  // RL17 RL21 - First stage divider
  assign tick1 = (cnt1_r >= first_div);
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt1_r <= 8'h00;
    end else if (tick1) begin
      cnt1_r <= 8'h00;
    end else begin
      cnt1_r <= cnt1_r + 8'h01;
    end
  end

  // RL3 RL4 RL5 RL6 - Status assembly
  always_comb begin
    status = 4'h0;
    status[dsu_pkg::DSU_ST_RECEIVE_OVERRUN] = overrun_r;
    status[dsu_pkg::DSU_ST_RECEIVE_FULL] = rxfull_r;
    status[dsu_pkg::DSU_ST_TRANSMIT_FULL] = txfull_r;
    status[dsu_pkg::DSU_ST_TRANSMITTER_RUNNING] = (tx_state_r == dsu_pkg::DSU_TX_SHIFT);
  end

  // RL7 RL13 - Read data mux
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_r <= 16'h0000;
    end else if (bus_i.rd) begin
      case (bus_i.addr)
        dsu_pkg::DSU_ADDR_LINE_STATUS: rdata_r <= {12'h000, status};
        dsu_pkg::DSU_ADDR_BYTE_LOW: rdata_r <= {8'h00, rx_hold_r};
        dsu_pkg::DSU_ADDR_BYTE_HIGH: rdata_r <= {rx_hold_r, 8'h00};
        dsu_pkg::DSU_ADDR_BIT_RATE_DIVIDER: rdata_r <= div_r;
        default: rdata_r <= 16'h0000;
      endcase
    end else begin
      rdata_r <= 16'h0000;
    end
  end

  // Transmit start conditions
  assign tx_bit_end = tick1 && period_end(tx_cnt_r, second_div);
  assign frame_done = (tx_state_r == dsu_pkg::DSU_TX_SHIFT) && tx_bit_end &&
                      (tx_bit_r == dsu_pkg::DSU_FRAME_LAST_BIT);
  // RL11 - Idle write starts
  assign start_direct = wr_byte && (tx_state_r == dsu_pkg::DSU_TX_IDLE) && !txfull_r;
  // RL12 - Held byte starts
  assign start_hold = txfull_r && ((tx_state_r == dsu_pkg::DSU_TX_IDLE) || frame_done);
  assign tx_byte = txfull_r ? tx_hold_r : wbyte;

  // RL5 RL12 - Holding register
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      txfull_r <= 1'b0;
      tx_hold_r <= dsu_pkg::DSU_BYTE_RESET;
    end else if (start_hold) begin
      txfull_r <= 1'b0;
    end else if (wr_byte && (tx_state_r == dsu_pkg::DSU_TX_SHIFT) && !txfull_r) begin
      txfull_r <= 1'b1;
      tx_hold_r <= wbyte;
    end
  end

  // RL1 RL2 RL6 - Transmit shifter
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tx_state_r <= dsu_pkg::DSU_TX_IDLE;
      tx_shift_r <= 10'h3ff;
      tx_bit_r <= 4'h0;
      tx_cnt_r <= 8'h00;
    end else if (start_direct || start_hold) begin
      tx_state_r <= dsu_pkg::DSU_TX_SHIFT;
      tx_shift_r <= {1'b1, tx_byte, 1'b0};
      tx_bit_r <= 4'h0;
      tx_cnt_r <= 8'h00;
    end else begin
      case (tx_state_r)
        dsu_pkg::DSU_TX_SHIFT: begin
          if (tx_bit_end) begin
            tx_cnt_r <= 8'h00;
            tx_shift_r <= {1'b1, tx_shift_r[9:1]};
            tx_bit_r <= tx_bit_r + 4'h1;
            if (frame_done) begin
              tx_state_r <= dsu_pkg::DSU_TX_IDLE;
            end
          end else if (tick1) begin
            tx_cnt_r <= tx_cnt_r + 8'h01;
          end
        end
        default: begin
          tx_shift_r <= 10'h3ff;
        end
      endcase
    end
  end

  // RL11 - Transmit interrupt pulse
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tx_irq_r <= 1'b0;
    end else begin
      tx_irq_r <= start_direct || start_hold;
    end
  end

  // RL20 - Good stop bit
  assign rx_take = (rx_state_r == dsu_pkg::DSU_RX_STOP) && tick1 &&
                   period_end(rx_cnt_r, second_div) && rxd_i;

  // Receive edge history
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rx_prev_r <= 1'b1;
    end else begin
      rx_prev_r <= rxd_i;
    end
  end

  // RL18 RL19 RL21 RL23 - Receive sequencer
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rx_state_r <= dsu_pkg::DSU_RX_IDLE;
      rx_cnt_r <= 8'h00;
      rx_bits_r <= 3'h0;
      rx_shift_r <= dsu_pkg::DSU_BYTE_RESET;
    end else begin
      case (rx_state_r)
        dsu_pkg::DSU_RX_IDLE: begin
          rx_cnt_r <= 8'h00;
          // RL18 - Falling edge detect
          if (rx_prev_r && !rxd_i) begin
            rx_state_r <= dsu_pkg::DSU_RX_START;
          end
        end
        dsu_pkg::DSU_RX_START: begin
          if (tick1 && period_end(rx_cnt_r, second_div >> 1)) begin
            rx_cnt_r <= 8'h00;
            rx_bits_r <= 3'h0;
            rx_state_r <= rxd_i ? dsu_pkg::DSU_RX_IDLE : dsu_pkg::DSU_RX_DATA;
          end else if (tick1) begin
            rx_cnt_r <= rx_cnt_r + 8'h01;
          end
        end
        dsu_pkg::DSU_RX_DATA: begin
          // RL19 - Mid-bit sampling
          if (tick1 && period_end(rx_cnt_r, second_div)) begin
            rx_cnt_r <= 8'h00;
            rx_shift_r <= {rxd_i, rx_shift_r[7:1]};
            rx_bits_r <= rx_bits_r + 3'h1;
            if (rx_bits_r == dsu_pkg::DSU_DATA_LAST_BIT) begin
              rx_state_r <= dsu_pkg::DSU_RX_STOP;
            end
          end else if (tick1) begin
            rx_cnt_r <= rx_cnt_r + 8'h01;
          end
        end
        dsu_pkg::DSU_RX_STOP: begin
          // RL23 - Stop bit check
          if (tick1 && period_end(rx_cnt_r, second_div)) begin
            rx_cnt_r <= 8'h00;
            rx_state_r <= dsu_pkg::DSU_RX_IDLE;
          end else if (tick1) begin
            rx_cnt_r <= rx_cnt_r + 8'h01;
          end
        end
        default: begin
          rx_state_r <= dsu_pkg::DSU_RX_IDLE;
        end
      endcase
    end
  end

  // RL3 RL4 RL8 RL9 RL20 - Receive holding and flags
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rx_hold_r <= dsu_pkg::DSU_BYTE_RESET;
      rxfull_r <= 1'b0;
      overrun_r <= 1'b0;
      rx_irq_r <= 1'b0;
    end else begin
      rx_irq_r <= rx_take;
      if (rx_take) begin
        rx_hold_r <= rx_shift_r;
        overrun_r <= rxfull_r;
        rxfull_r <= 1'b1;
      end else if (rd_data) begin
        rxfull_r <= 1'b0;
      end
    end
  end

  assign rdata_o = rdata_r;
  assign txd_o = tx_shift_r[0];
  assign tx_irq_o = tx_irq_r;
  assign rx_irq_o = rx_irq_r;

endmodule // dsu_uart
`default_nettype wire
